// File: inc/vsc_pkg.sv
package vsc_pkg;
  // Assembled CRTC timing values
  typedef struct packed {
    logic [9:0] vtotal;
    logic [9:0] vdisp_end;
    logic [9:0] vblank_start;
    logic [9:0] vblank_end;
    logic [9:0] vsync_start;
    logic [9:0] line_cmp;
    logic [7:0] hblank_end;
    logic [8:0] row_offset;
    logic [19:0] start_addr;
  } vsc_timing_t;
  // Registered CPU memory routing
  typedef struct packed {
    logic [21:0] addr;
    logic [3:0] plane_we;
    logic [3:0] blt_byte_en;
    logic [1:0] rd_plane;
  } vsc_memroute_t;
endpackage

// File: inc/vsc_regs.svh
`ifndef VSC_REGS_SVH
`define VSC_REGS_SVH
// I/O port addresses
`define VSC_PORT_SEQ_IDX 16'h03C4
`define VSC_PORT_SEQ_DAT 16'h03C5
`define VSC_PORT_CRT_IDX 16'h03D4
`define VSC_PORT_CRT_DAT 16'h03D5
// Sequencer indices
`define VSC_SR_RESET 5'h00
`define VSC_SR_CLOCK 5'h01
`define VSC_SR_PLANE 5'h02
`define VSC_SR_CMAP 5'h03
`define VSC_SR_MEM 5'h04
// Writable bit masks, reserved bits are zero
`define VSC_MSK_SEQ_IDX 8'h1F
`define VSC_MSK_CRT_IDX 8'h3F
`define VSC_MSK_RCTL 8'h03
`define VSC_MSK_CMODE 8'h3D
`define VSC_MSK_PMASK 8'h0F
`define VSC_MSK_CMAP 8'h3F
`define VSC_MSK_MMODE 8'h0E
// Reset values
`define VSC_RST_RCTL 8'h03
`define VSC_RST_ZERO 8'h00
// Bit positions
`define VSC_B_SYNC_RST 1
`define VSC_B_ASYNC_RST 0
`define VSC_B_FULL_BW 5
`define VSC_B_SL32 4
`define VSC_B_DOT_DIV2 3
`define VSC_B_SL16 2
`define VSC_B_CHAR8 0
`define VSC_B_CHAIN4 3
`define VSC_B_ODD_EVEN 2
`define VSC_B_EXT_MEM 1
`define VSC_B_ATTR_SET 3
// CRTC register count held and timing indices
`define VSC_CR_COUNT 32
`define VSC_CR_HT 5'h00
`define VSC_CR_HDE 5'h01
`define VSC_CR_HBS 5'h02
`define VSC_CR_HBE 5'h03
`define VSC_CR_HSS 5'h04
`define VSC_CR_HSE 5'h05
`define VSC_CR_VT 5'h06
`define VSC_CR_OVF 5'h07
`define VSC_CR_MSL 5'h09
`define VSC_CR_SAH 5'h0C
`define VSC_CR_SAL 5'h0D
`define VSC_CR_VSS 5'h10
`define VSC_CR_VSE 5'h11
`define VSC_CR_VDE 5'h12
`define VSC_CR_OFS 5'h13
`define VSC_CR_VBS 5'h15
`define VSC_CR_VBE 5'h16
`define VSC_CR_LC 5'h18
`define VSC_CR_MTX 5'h1A
`define VSC_CR_EDC 5'h1B
`define VSC_CR_OVX 5'h1D
// Timing offsets: fields hold total minus five and minus two
`define VSC_HT_ADJ 9'h004
`define VSC_VT_ADJ 10'h001
`define VSC_HDE_ADJ 9'h001
// Dot counter last values for 8 and 9 dot characters
`define VSC_DOT_LAST8 4'h7
`define VSC_DOT_LAST9 4'h8
`define VSC_LOAD_LAST4 2'h3
// Plane masks and 64K limit
`define VSC_PL_EVEN 4'h5
`define VSC_PL_ODD 4'hA
`define VSC_PL_ALL 4'hF
`define VSC_MEM64K_MSK 22'h00FFFF
`endif

// File: logic/vsc_seq_crtc.sv
`timescale 1ns/1ps
`include "vsc_regs.svh"

// Notes on behaviour
// - Sync reset bit low halts all refresh
// - Async reset bit low halts, clears map select
// - Full bandwidth blanks and stops screen refresh; syncs and memory refresh continue
// - Shifters load every 1, 2, 4 chars
// - Dot clock halves video clock when set
// - Character clock is dot clock over 8/9
// - Plane enables gate CPU plane writes
// - Byte masking lets enables steer block transfer
// - Secondary map from bits 5,3,2 to offset
// - Primary map from bits 4,1,0, same table
// - Text: code plane 0, attr 1, font 2
// - Differing maps plus ext memory give 512 chars
// - Font address: map, code, row
// - Four-way chain uses A1:A0, beats odd/even
// - Four-way chain ignores read plane select
// - Odd/even: even to 0/2, odd to 1/3
// - Ext memory bit low limits memory to 64K
// - CRTC index picks CRTC data port target
// - Char counter wraps at total plus five
// - Timing values gain overflow extension bits
// - Start address is twenty bits from extensions
// - Sequencer index picks sequencer data target
module vsc_seq_crtc
  import vsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  // Host I/O port bus
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Graphics controller control bits
  input wire logic blt_mask_en,
  input wire logic [1:0] read_plane_select,
  // CPU memory access
  input wire logic cpu_req,
  input wire logic [21:0] cpu_addr,
  output vsc_memroute_t mem_route,
  // Text fetch
  input wire logic text_fetch,
  input wire logic [7:0] plane0_code,
  input wire logic [7:0] plane1_attr,
  input wire logic [4:0] char_row,
  output logic [15:0] font_addr,
  output logic font_intensity,
  // Display timing
  output logic char_clk_en,
  output logic shift_load,
  output logic hsync,
  output logic vsync,
  output logic blank_n,
  output logic screen_refresh_en,
  output logic mem_refresh_en,
  output vsc_timing_t timing
);

  // ----------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------
  // Map number to the top three font address bits: 16K steps
  // for the low two map bits, 8K step for the high bit
  function automatic logic [2:0] map_bits(input logic [2:0] m);
    map_bits = {m[1:0], m[2]};
  endfunction

  // Port address match
  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] p);
    hit = (a == p);
  endfunction

  // ----------------------------------------------------------
  // Register state
  // ----------------------------------------------------------
  logic [7:0] seq_idx_r; // Sequencer index
  logic [7:0] crt_idx_r; // CRTC index
  logic [7:0] seq_reset_ctrl_r;
  logic [7:0] seq_clocking_mode_r;
  logic [7:0] seq_plane_write_mask_r;
  logic [7:0] seq_char_map_select_r;
  logic [7:0] seq_memory_mode_r;
  // CRTC register file; upper indices are not implemented
  logic [7:0] crt_r [0:`VSC_CR_COUNT-1];
  logic [7:0] io_rdata_r;

  // ----------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------
  wire wr_seq_idx = io_wr & hit(io_addr, `VSC_PORT_SEQ_IDX);
  wire wr_seq_dat = io_wr & hit(io_addr, `VSC_PORT_SEQ_DAT);
  wire wr_crt_idx = io_wr & hit(io_addr, `VSC_PORT_CRT_IDX);
  wire wr_crt_dat = io_wr & hit(io_addr, `VSC_PORT_CRT_DAT);
  wire [4:0] sidx = seq_idx_r[4:0];
  wire [5:0] cidx = crt_idx_r[5:0];
  // Only the low half of the CRTC index space is stored
  wire cidx_ok = ~cidx[5];
  wire [4:0] cslot = cidx[4:0];
  wire wr_rctl = wr_seq_dat & (sidx == `VSC_SR_RESET);
  wire wr_cmode = wr_seq_dat & (sidx == `VSC_SR_CLOCK);
  wire wr_pmask = wr_seq_dat & (sidx == `VSC_SR_PLANE);
  wire wr_cmap = wr_seq_dat & (sidx == `VSC_SR_CMAP);
  wire wr_mmode = wr_seq_dat & (sidx == `VSC_SR_MEM);
  wire wr_cr = wr_crt_dat & cidx_ok;

  // Control bits
  wire sync_run = seq_reset_ctrl_r[`VSC_B_SYNC_RST];
  wire async_run = seq_reset_ctrl_r[`VSC_B_ASYNC_RST];
  wire seq_run = sync_run & async_run;
  wire full_bw = seq_clocking_mode_r[`VSC_B_FULL_BW];
  wire chain4 = seq_memory_mode_r[`VSC_B_CHAIN4];
  wire odd_even_n = seq_memory_mode_r[`VSC_B_ODD_EVEN];
  wire ext_mem = seq_memory_mode_r[`VSC_B_EXT_MEM];

  // Read data selection
  logic [7:0] seq_rd;
  always_comb begin
    // Unimplemented sequencer indices read as zero
    case (sidx)
      `VSC_SR_RESET: seq_rd = seq_reset_ctrl_r;
      `VSC_SR_CLOCK: seq_rd = seq_clocking_mode_r;
      `VSC_SR_PLANE: seq_rd = seq_plane_write_mask_r;
      `VSC_SR_CMAP: seq_rd = seq_char_map_select_r;
      `VSC_SR_MEM: seq_rd = seq_memory_mode_r;
      default: seq_rd = `VSC_RST_ZERO;
    endcase
  end
  wire [7:0] crt_rd = cidx_ok ? crt_r[cslot] : `VSC_RST_ZERO;
  wire [7:0] rd_mux =
    hit(io_addr, `VSC_PORT_SEQ_IDX) ? seq_idx_r :
    hit(io_addr, `VSC_PORT_SEQ_DAT) ? seq_rd :
    hit(io_addr, `VSC_PORT_CRT_IDX) ? crt_idx_r :
    hit(io_addr, `VSC_PORT_CRT_DAT) ? crt_rd : `VSC_RST_ZERO;

  // ----------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------
  // Indices and sequencer registers except map select; masks drop reserved bits
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      seq_idx_r <= `VSC_RST_ZERO;
      crt_idx_r <= `VSC_RST_ZERO;
      seq_reset_ctrl_r <= `VSC_RST_RCTL;
      seq_clocking_mode_r <= `VSC_RST_ZERO;
      seq_plane_write_mask_r <= `VSC_RST_ZERO;
      seq_memory_mode_r <= `VSC_RST_ZERO;
    end else begin
      if (wr_seq_idx)
        seq_idx_r <= io_wdata & `VSC_MSK_SEQ_IDX;
      if (wr_crt_idx)
        crt_idx_r <= io_wdata & `VSC_MSK_CRT_IDX;
      if (wr_rctl)
        seq_reset_ctrl_r <= io_wdata & `VSC_MSK_RCTL;
      if (wr_cmode)
        seq_clocking_mode_r <= io_wdata & `VSC_MSK_CMODE;
      if (wr_pmask)
        seq_plane_write_mask_r <= io_wdata & `VSC_MSK_PMASK;
      if (wr_mmode)
        seq_memory_mode_r <= io_wdata & `VSC_MSK_MMODE;
    end
  end

  // Map select is held clear while the async reset bit is low;
  // a write in that state is lost on purpose
  always_ff @(posedge mclk) begin
    if (!rstn || !async_run)
      seq_char_map_select_r <= `VSC_RST_ZERO;
    else if (wr_cmap)
      seq_char_map_select_r <= io_wdata & `VSC_MSK_CMAP;
  end

  // CRTC file has no reset of its own content beyond zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      for (int i = 0; i < `VSC_CR_COUNT; i++)
        crt_r[i] <= `VSC_RST_ZERO;
    end else if (wr_cr) begin
      crt_r[cslot] <= io_wdata;
    end
  end

  // Read data is registered: valid the cycle after io_rd
  always_ff @(posedge mclk) begin
    if (!rstn)
      io_rdata_r <= `VSC_RST_ZERO;
    else if (io_rd)
      io_rdata_r <= rd_mux;
  end
  assign io_rdata = io_rdata_r;

  // ----------------------------------------------------------
  // Timing field assembly
  // ----------------------------------------------------------
  wire [7:0] ovf = crt_r[`VSC_CR_OVF];
  wire [7:0] msl = crt_r[`VSC_CR_MSL];
  wire [7:0] mtx = crt_r[`VSC_CR_MTX];
  wire [7:0] edc = crt_r[`VSC_CR_EDC];
  assign timing.vtotal = {ovf[5], ovf[0], crt_r[`VSC_CR_VT]};
  assign timing.vdisp_end = {ovf[6], ovf[1], crt_r[`VSC_CR_VDE]};
  assign timing.vblank_start = {msl[5], ovf[3], crt_r[`VSC_CR_VBS]};
  assign timing.vblank_end = {mtx[7], mtx[6], crt_r[`VSC_CR_VBE]};
  assign timing.vsync_start = {ovf[7], ovf[2], crt_r[`VSC_CR_VSS]};
  assign timing.line_cmp = {msl[6], ovf[4], crt_r[`VSC_CR_LC]};
  assign timing.hblank_end = {mtx[5], mtx[4],
                              crt_r[`VSC_CR_HSE][7],
                              crt_r[`VSC_CR_HBE][4:0]};
  assign timing.row_offset = {edc[4], crt_r[`VSC_CR_OFS]};
  assign timing.start_addr = {crt_r[`VSC_CR_OVX][7], edc[3:2],
                              edc[0], crt_r[`VSC_CR_SAH],
                              crt_r[`VSC_CR_SAL]};

  // ----------------------------------------------------------
  // Dot and character clock enables
  // ----------------------------------------------------------
  logic dot_ph_r; // Half rate phase
  logic [3:0] dot_cnt_r; // Dots within a character
  logic [1:0] load_cnt_r; // Characters within a load group
  wire dot_tick = seq_clocking_mode_r[`VSC_B_DOT_DIV2] ?
                  dot_ph_r : 1'b1;
  wire [3:0] dot_last = seq_clocking_mode_r[`VSC_B_CHAR8] ?
                        `VSC_DOT_LAST8 : `VSC_DOT_LAST9;
  wire char_tick = seq_run & dot_tick & (dot_cnt_r == dot_last);
  wire load_due = seq_clocking_mode_r[`VSC_B_SL32] ?
                  (load_cnt_r == `VSC_LOAD_LAST4) :
                  seq_clocking_mode_r[`VSC_B_SL16] ?
                  load_cnt_r[0] : 1'b1;

  // Dividers clear while halted so restart begins aligned
  always_ff @(posedge mclk) begin
    if (!rstn || !seq_run) begin
      dot_ph_r <= 1'b0;
      dot_cnt_r <= 4'h0;
      load_cnt_r <= 2'h0;
    end else begin
      dot_ph_r <= ~dot_ph_r;
      if (dot_tick)
        dot_cnt_r <= (dot_cnt_r == dot_last) ? 4'h0 :
                     dot_cnt_r + 4'h1;
      if (char_tick)
        load_cnt_r <= load_cnt_r + 2'h1;
    end
  end

  // ----------------------------------------------------------
  // Character and line counters
  // ----------------------------------------------------------
  logic [8:0] hcnt_r;
  logic [9:0] vcnt_r;
  wire [8:0] h_last = {1'b0, crt_r[`VSC_CR_HT]} + `VSC_HT_ADJ;
  wire [9:0] v_last = timing.vtotal + `VSC_VT_ADJ;
  wire h_wrap = hcnt_r == h_last;
  wire v_wrap = vcnt_r == v_last;
  wire [8:0] hde = {1'b0, crt_r[`VSC_CR_HDE]};

  // Counters run under full bandwidth, so syncs continue
  always_ff @(posedge mclk) begin
    if (!rstn || !seq_run) begin
      hcnt_r <= 9'h000;
      vcnt_r <= 10'h000;
    end else if (char_tick) begin
      hcnt_r <= h_wrap ? 9'h000 : hcnt_r + 9'h001;
      if (h_wrap)
        vcnt_r <= v_wrap ? 10'h000 : vcnt_r + 10'h001;
    end
  end

  // ----------------------------------------------------------
  // Sync, blank and refresh outputs
  // ----------------------------------------------------------
  logic hs_r, vs_r, blank_n_r, load_r, cce_r;
  wire hs_on = hcnt_r[7:0] == crt_r[`VSC_CR_HSS];
  wire hs_off = hcnt_r[4:0] == crt_r[`VSC_CR_HSE][4:0];
  wire vs_on = vcnt_r == timing.vsync_start;
  wire vs_off = vcnt_r[3:0] == crt_r[`VSC_CR_VSE][3:0];
  wire h_act = hcnt_r < (hde + `VSC_HDE_ADJ);
  wire v_act = vcnt_r <= timing.vdisp_end;

  // Syncs change on character boundaries only
  always_ff @(posedge mclk) begin
    if (!rstn || !seq_run) begin
      hs_r <= 1'b0;
      vs_r <= 1'b0;
      blank_n_r <= 1'b0;
      load_r <= 1'b0;
      cce_r <= 1'b0;
    end else begin
      cce_r <= char_tick;
      load_r <= char_tick & load_due;
      if (char_tick && hs_on)
        hs_r <= 1'b1;
      else if (char_tick && hs_off)
        hs_r <= 1'b0;
      if (char_tick && h_wrap && vs_on)
        vs_r <= 1'b1;
      else if (char_tick && h_wrap && vs_off)
        vs_r <= 1'b0;
      // Blank held active under full bandwidth
      blank_n_r <= ~full_bw & h_act & v_act;
    end
  end
  assign char_clk_en = cce_r;
  assign shift_load = load_r;
  assign hsync = hs_r;
  assign vsync = vs_r;
  assign blank_n = blank_n_r;
  assign screen_refresh_en = seq_run & ~full_bw;
  assign mem_refresh_en = seq_run;

  // ----------------------------------------------------------
  // CPU plane routing
  // ----------------------------------------------------------
  vsc_memroute_t route_r;
  wire [3:0] pl_sel =
    chain4 ? (4'h1 << cpu_addr[1:0]) :
    !odd_even_n ? (cpu_addr[0] ? `VSC_PL_ODD : `VSC_PL_EVEN) :
    `VSC_PL_ALL;
  wire [1:0] rd_sel =
    chain4 ? cpu_addr[1:0] :
    !odd_even_n ? {read_plane_select[1], cpu_addr[0]} :
    read_plane_select;
  wire [21:0] chain_addr =
    chain4 ? {2'b00, cpu_addr[21:2]} :
    !odd_even_n ? {1'b0, cpu_addr[21:1]} : cpu_addr;
  wire [21:0] lim_addr = ext_mem ? chain_addr :
                         (chain_addr & `VSC_MEM64K_MSK);
  wire [3:0] pmask = seq_plane_write_mask_r[3:0];

  // Routing is captured per request; last value holds between
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      route_r <= '0;
    end else if (cpu_req) begin
      route_r.addr <= lim_addr;
      route_r.plane_we <= pl_sel & pmask;
      route_r.blt_byte_en <= blt_mask_en ? pmask :
                             `VSC_PL_ALL;
      route_r.rd_plane <= rd_sel;
    end
  end
  assign mem_route = route_r;

  // ----------------------------------------------------------
  // Text font addressing
  // ----------------------------------------------------------
  logic [15:0] font_addr_r;
  logic font_int_r;
  wire [7:0] cms = seq_char_map_select_r;
  wire [2:0] sec_map = {cms[5], cms[3], cms[2]};
  wire [2:0] pri_map = {cms[4], cms[1], cms[0]};
  wire dual_set = (pri_map != sec_map) & ext_mem;
  wire [2:0] use_map =
    (dual_set && plane1_attr[`VSC_B_ATTR_SET]) ? sec_map : pri_map;

  // Code comes from plane 0, attribute from plane 1; the
  // result addresses plane 2
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      font_addr_r <= 16'h0000;
      font_int_r <= 1'b0;
    end else if (text_fetch) begin
      font_addr_r <= {map_bits(use_map), plane0_code,
                      char_row};
      font_int_r <= ~dual_set & plane1_attr[`VSC_B_ATTR_SET];
    end
  end
  assign font_addr = font_addr_r;
  assign font_intensity = font_int_r;

endmodule

// File: tb/vsc_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host CPU on the indexed I/O port bus
// ----------------------------------------
module vsc_host_model (
  input wire logic mclk,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  // Idle bus from time zero
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'hA5;
  end
  // Strobe held up to the sampling edge; data then inverted
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
    io_wdata <= ~d;
  endtask
  // Read data is registered, so it is taken once settled
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    @(negedge mclk);
    d = io_rdata;
  endtask
  // No auto increment, so the index goes first every time
  task automatic wr_ix(input logic [15:0] p, input logic [7:0] i,
                       input logic [7:0] d);
    wr(p, i);
    wr(p + 16'h0001, d);
  endtask
  task automatic rd_ix(input logic [15:0] p, input logic [7:0] i,
                       output logic [7:0] d);
    wr(p, i);
    rd(p + 16'h0001, d);
  endtask
endmodule

// File: tb/vsc_seq_crtc_props.sv
`timescale 1ns/1ps
// ------------------------------------------
// Port-level checks for the sequencer block
// ------------------------------------------
module vsc_seq_crtc_props
  import vsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic blt_mask_en,
  input wire logic cpu_req,
  input wire vsc_memroute_t mem_route,
  input wire logic text_fetch,
  input wire logic [7:0] plane0_code,
  input wire logic [4:0] char_row,
  input wire logic [15:0] font_addr,
  input wire logic char_clk_en,
  input wire logic shift_load,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic blank_n,
  input wire logic screen_refresh_en,
  input wire logic mem_refresh_en
);
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Stopped screen refresh forces blanking on the next edge
  chk_blank_no_refresh: assert property (
    !screen_refresh_en |=> !blank_n)
    else $error("blank_n high while screen refresh stopped");
  chk_screen_needs_mem: assert property (
    screen_refresh_en |-> mem_refresh_en)
    else $error("screen refresh without memory refresh");
  // Halted sequencer: timing outputs settle quiet
  chk_halt_quiet: assert property (
    !mem_refresh_en [*3] |-> !char_clk_en && !shift_load && !hsync && !vsync)
    else $error("timing active while sequencer halted");
  // Eight dots is the shortest character, so no tick sooner
  chk_char_gap: assert property (
    char_clk_en |=> !char_clk_en [*7])
    else $error("character clocks closer than eight cycles");
  chk_load_on_char: assert property (
    shift_load |-> char_clk_en)
    else $error("shifter load off a character clock");
  chk_font_fields: assert property (
    text_fetch |=> font_addr[12:0] == {$past(plane0_code), $past(char_row)})
    else $error("font address code or row field wrong");
  chk_blt_all_bytes: assert property (
    cpu_req && !blt_mask_en |=> mem_route.blt_byte_en == 4'hF)
    else $error("block bytes masked while masking off");
  chk_we_in_mask: assert property (
    cpu_req |=> (mem_route.plane_we & ~mem_route.blt_byte_en) == 4'h0)
    else $error("plane write outside the byte mask");
  chk_route_hold: assert property (
    !cpu_req |=> $stable(mem_route))
    else $error("route changed without a request");
  chk_rdata_hold: assert property (
    !io_rd |=> $stable(io_rdata))
    else $error("read data changed without a read");
endmodule

bind vsc_seq_crtc vsc_seq_crtc_props u_props (
  .mclk(mclk), .rstn(rstn), .io_rd(io_rd), .io_rdata(io_rdata),
  .blt_mask_en(blt_mask_en), .cpu_req(cpu_req), .mem_route(mem_route),
  .text_fetch(text_fetch), .plane0_code(plane0_code),
  .char_row(char_row), .font_addr(font_addr), .char_clk_en(char_clk_en),
  .shift_load(shift_load), .hsync(hsync), .vsync(vsync),
  .blank_n(blank_n), .screen_refresh_en(screen_refresh_en),
  .mem_refresh_en(mem_refresh_en)
);

// File: tb/vsc_seq_crtc_test.sv
`timescale 1ns/1ps
`include "vsc_regs.svh"
module vsc_seq_crtc_test;
  import vsc_pkg::*;
  // ----------------------------------------
  // Clock, reset and design signals
  // ----------------------------------------
  localparam logic [15:0] SQ = `VSC_PORT_SEQ_IDX;
  localparam logic [15:0] CR = `VSC_PORT_CRT_IDX;
  logic mclk = 1'b0, rstn = 1'b0;
  logic blt_mask_en = 1'b0, cpu_req = 1'b0, text_fetch = 1'b0;
  logic [1:0] read_plane_select = 2'h0;
  logic [21:0] cpu_addr = 22'h000000;
  logic [7:0] plane0_code = 8'h00, plane1_attr = 8'h00, io_wdata, io_rdata;
  logic [4:0] char_row = 5'h00;
  logic [15:0] io_addr, font_addr;
  logic io_wr, io_rd, font_intensity, char_clk_en, shift_load;
  logic hsync, vsync, blank_n, screen_refresh_en, mem_refresh_en;
  vsc_memroute_t mem_route;
  vsc_timing_t timing;
  int error_cnt = 0, n_checks = 0;
  always #12.5 mclk = ~mclk;
  vsc_seq_crtc uut (.mclk(mclk), .rstn(rstn), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .blt_mask_en(blt_mask_en), .read_plane_select(read_plane_select),
    .cpu_req(cpu_req), .cpu_addr(cpu_addr), .mem_route(mem_route),
    .text_fetch(text_fetch), .plane0_code(plane0_code),
    .plane1_attr(plane1_attr), .char_row(char_row), .font_addr(font_addr),
    .font_intensity(font_intensity), .char_clk_en(char_clk_en),
    .shift_load(shift_load), .hsync(hsync), .vsync(vsync),
    .blank_n(blank_n), .screen_refresh_en(screen_refresh_en),
    .mem_refresh_en(mem_refresh_en), .timing(timing));
  vsc_host_model h (.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cycles between the 2nd and 3rd rise, skipping mode-change transients
  task automatic gap(input int s, output int n);
    logic p, c;
    int t, e, t0;
    p = 1'b1; e = 0; t = 0; t0 = 0; n = -1;
    while (e < 3 && t < 400) begin
      @(negedge mclk);
      t++;
      c = (s == 0) ? char_clk_en : (s == 1) ? shift_load : hsync;
      if (c === 1'b1 && p === 1'b0) begin
        e++;
        if (e == 2) t0 = t;
        if (e == 3) n = t - t0;
      end
      p = c;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, reserved bits, index widths, unmapped places
  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] rv [5] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] mk [5] = '{8'h03, 8'h3D, 8'h0F, 8'h3F, 8'h0E};
    for (int i = 0; i < 5; i++) begin
      h.rd_ix(SQ, 8'(i), d);
      chk("seq reset value", d, rv[i]);
      h.wr_ix(SQ, 8'(i), 8'hFF);
      h.rd_ix(SQ, 8'(i), d);
      chk("seq reserved bits", d, mk[i]);
      if (i > 0) h.wr_ix(SQ, 8'(i), 8'h00);
    end
    h.wr(SQ, 8'hFF);
    h.rd(SQ, d);
    chk("seq index width", d, 8'h1F);
    h.rd_ix(SQ, 8'h05, d);
    chk("seq unmapped index", d, 8'h00);
    h.wr(CR, 8'hFF);
    h.rd(CR, d);
    chk("crtc index width", d, 8'h3F);
    h.rd(16'h03C0, d);
    chk("unmapped port", d, 8'h00);
  endtask
  // Synchronous and asynchronous reset bits
  task automatic t_reset_bits();
    logic [7:0] d;
    h.wr_ix(SQ, 8'h03, 8'h2A);
    h.wr_ix(SQ, 8'h00, 8'h01);
    repeat (20) @(negedge mclk);
    chk("mem refresh halted", mem_refresh_en, 1'b0);
    chk("char clock halted", char_clk_en, 1'b0);
    h.wr_ix(CR, 8'h00, 8'h00);
    h.rd_ix(SQ, 8'h03, d);
    chk("map kept on sync reset", d, 8'h2A);
    h.wr_ix(SQ, 8'h00, 8'h02);
    h.rd_ix(SQ, 8'h03, d);
    chk("map cleared", d, 8'h00);
    h.wr_ix(SQ, 8'h03, 8'h3F);
    h.rd_ix(SQ, 8'h03, d);
    chk("map held clear", d, 8'h00);
    h.wr_ix(SQ, 8'h00, 8'h03);
    @(negedge mclk);
    chk("screen refresh back", screen_refresh_en, 1'b1);
  endtask
  // CRTC data port and assembled fields
  task automatic t_crtc();
    logic [7:0] d;
    h.wr_ix(CR, 8'h00, 8'h5A);
    h.wr_ix(CR, 8'h01, 8'hA5);
    h.rd_ix(CR, 8'h00, d);
    chk("crtc reg 0", d, 8'h5A);
    h.rd_ix(CR, 8'h01, d);
    chk("crtc reg 1", d, 8'hA5);
    h.wr_ix(CR, 8'h20, 8'h77);
    h.rd_ix(CR, 8'h20, d);
    chk("crtc beyond file", d, 8'h00);
    h.wr_ix(CR, 8'h06, 8'h34);
    h.wr_ix(CR, 8'h07, 8'h63);
    h.wr_ix(CR, 8'h0D, 8'h11);
    h.wr_ix(CR, 8'h0C, 8'h22);
    h.wr_ix(CR, 8'h1B, 8'h0D);
    h.wr_ix(CR, 8'h1D, 8'h80);
    @(negedge mclk);
    chk("vertical total", timing.vtotal, 10'h334);
    chk("start address", timing.start_addr, 20'hF2211);
  endtask
  // CPU routing in every addressing mode
  task automatic t_route();
    logic [7:0] md [5] = '{8'h0A, 8'h08, 8'h02, 8'h06, 8'h04};
    logic [21:0] a, ea;
    logic [3:0] sel;
    logic [1:0] rp;
    read_plane_select <= 2'b10;
    h.wr_ix(SQ, 8'h02, 8'h09);
    for (int m = 0; m < 5; m++) begin
      h.wr_ix(SQ, 8'h04, md[m]);
      for (int k = 0; k < 2; k++) begin
        a = k ? 22'h3FFFE : 22'h12347;
        if (md[m][3]) begin
          ea = a >> 2; sel = 4'h1 << a[1:0]; rp = a[1:0];
        end else if (!md[m][2]) begin
          ea = a >> 1; sel = a[0] ? 4'hA : 4'h5; rp = {1'b1, a[0]};
        end else begin
          ea = a; sel = 4'hF; rp = 2'b10;
        end
        if (!md[m][1]) ea = ea & 22'h00FFFF;
        @(posedge mclk);
        cpu_req <= 1'b1;
        cpu_addr <= a;
        blt_mask_en <= k[0];
        @(posedge mclk);
        cpu_req <= 1'b0;
        @(negedge mclk);
        chk("route", mem_route, {ea, sel & 4'h9, k ? 4'h9 : 4'hF, rp});
      end // Same compare also
    end
  endtask
  // Font address from map selects, code and row
  task automatic fetch(input logic [7:0] cm, input logic [7:0] at,
                       input logic [15:0] ea, input logic ei);
    h.wr_ix(SQ, 8'h03, cm);
    @(posedge mclk);
    text_fetch <= 1'b1;
    plane0_code <= cm ^ 8'h41;
    plane1_attr <= at;
    char_row <= 5'(cm);
    @(posedge mclk);
    text_fetch <= 1'b0;
    @(negedge mclk);
    chk("font addr", font_addr, ea | {(cm ^ 8'h41), 5'(cm)});
    chk("intensity", font_intensity, ei);
  endtask
  task automatic t_font();
    logic [15:0] of [8] = '{16'h0000, 16'h4000, 16'h8000, 16'hC000,
                            16'h2000, 16'h6000, 16'hA000, 16'hE000};
    logic [2:0] n, s;
    h.wr_ix(SQ, 8'h04, 8'h02);
    for (int i = 0; i < 8; i++) begin
      n = 3'(i);
      s = ~n;
      fetch({2'b00, s[2], n[2], s[1], s[0], n[1], n[0]}, {4'h0, n[0], 3'h0},
            n[0] ? of[s] : of[n], 1'b0);
    end
    fetch(8'h3F, 8'h08, of[7], 1'b1);
    h.wr_ix(SQ, 8'h04, 8'h00);
    fetch(8'h21, 8'h08, of[1], 1'b1);
  endtask
  // Dot, character, load and line rates, then full bandwidth
  task automatic t_timing();
    logic [7:0] m [6] = '{8'h01, 8'h00, 8'h09, 8'h05, 8'h11, 8'h01};
    int sl [6] = '{0, 0, 0, 1, 1, 2};
    int ex [6] = '{8, 9, 16, 16, 32, 40};
    int n, hs = 0, bl = 0;
    h.wr_ix(CR, 8'h04, 8'h02);
    h.wr_ix(CR, 8'h05, 8'h03);
    for (int i = 0; i < 6; i++) begin
      h.wr_ix(SQ, 8'h01, m[i]);
      gap(sl[i], n);
      chk("pulse spacing", n, ex[i]);
    end
    h.wr_ix(SQ, 8'h01, 8'h21);
    @(posedge mclk);
    repeat (100) begin
      @(negedge mclk);
      hs += (hsync === 1'b1);
      bl += (blank_n !== 1'b0);
    end
    chk("blank while full bw", bl, 0);
    chk("hsync runs", hs > 0, 1);
    chk("mem refresh runs", mem_refresh_en, 1'b1);
    chk("screen refresh off", screen_refresh_en, 1'b0);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_crtc();
    t_reset_bits();
    t_route();
    t_font();
    t_timing();
    stop_test();
  end
  // Run is about a thousand cycles; wide margin
  initial begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end
endmodule
